// *** inc/pmu_regs_consts.vh ***
`ifndef PMU_REGS_CONSTS_VH
`define PMU_REGS_CONSTS_VH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define ADDR_W 12
`define IDX_PIN_CFG 10'h045
`define IDX_MON_CTRL 10'h046
`define IDX_LED_CURRENT 10'h047
`define IDX_LED_INTERVAL 10'h048
`define IDX_IRQ_STATUS 10'h050
`define IDX_IRQ_MASK 10'h051

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PIN_SLEEP_BIT 7
`define PIN_SRC_BIT 6
`define PIN_OD_BIT 5
`define PIN_DEB_BIT 4
`define PIN_PD_BIT 3
`define PIN_DIR_BIT 2
`define PIN_STS_BIT 1
`define PIN_SET_BIT 0
`define MON_DELAY_HI 6
`define MON_DELAY_LO 5
`define MON_MASK_BIT 4
`define MON_GOOD_BIT 3
`define MON_SEL_HI 1
`define MON_SEL_LO 0
`define LED_RAMP_BIT 5
`define LED_CUR_HI 3
`define LED_CUR_LO 0
`define LED_INT_HI 6
`define LED_INT_LO 0
`define IRQ_W 2
`define IRQ_SUPPLY_FALL 0
`define IRQ_PIN_CHANGE 1

// ----------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------
`define PIN_CFG_WMASK 8'hFD
`define MON_CTRL_WMASK 8'h73
`define LED_CUR_WMASK 8'h2F
`define LED_INT_WMASK 8'h7F
`define REG_RESET 8'h00
`define IRQ_RESET 2'h0

// ----------------------------------------------------------------
// codes
// ----------------------------------------------------------------
`define DELAY_NONE 2'h0
`define DELAY_50 2'h1
`define DELAY_100 2'h2
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

// ----------------------------------------------------------------
// timing; counts hold only for the 40 ns clock
// ----------------------------------------------------------------
`define LED_STEP_MS 64
`define DEB_SHORT_CYC 12'h92E
`define DEB_LONG_CYC 12'hF3C
`define MON_50_CYC 13'h4E2
`define MON_100_CYC 13'h9C4
`define MON_250_CYC 13'h186A
`define DEB_CNT_W 12
`define MON_CNT_W 13

`endif

// *** logic/pin_debounce.v ***
`timescale 1ns/10ps
`include "pmu_regs_consts.vh"

module pin_debounce (
    input wire core_clk,   // system clock
    input wire nrst,       // async reset, active low
    input wire sample_in,  // raw pad level
    input wire long_sel,   // 0 short window, 1 long window
    output reg level_q     // debounced level
);

    localparam [`DEB_CNT_W-1:0] SHORT_LIM = `DEB_SHORT_CYC;
    localparam [`DEB_CNT_W-1:0] LONG_LIM = `DEB_LONG_CYC;

    reg [`DEB_CNT_W-1:0] cnt_q;
    wire [`DEB_CNT_W-1:0] limit = long_sel ? LONG_LIM : SHORT_LIM;

    // ----------------------------------------------------------------
    // stability counter
    // ----------------------------------------------------------------
    // any bounce restarts the window, so a level must hold the full time
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= {`DEB_CNT_W{1'b0}};
            level_q <= 1'b0;
        end else if (sample_in == level_q) begin
            cnt_q <= {`DEB_CNT_W{1'b0}};
        end else if (cnt_q >= limit - 1'b1) begin
            cnt_q <= {`DEB_CNT_W{1'b0}};
            level_q <= sample_in;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

endmodule

// *** logic/pmu_pin_monitor_led_regs.v ***
// What this block does
// - sleep override bit forces an output pin low while in sleep
// - source select: 0 drives software value, 1 drives third LED output
// - drive type: 0 push-pull, 1 open-drain
// - pin input debounced for 94 us or 156 us by select bit
// - pulldown control bit enables the pad pulldown when set
// - direction bit: 0 input, 1 output
// - pin level status reads the live pad level, no reset value
// - software value bit sets the driven pin level
// - delay field delays only supply-good falling edge: 0/50/100/250 us
// - switch-off mask makes a low monitor result a switch-off event
// - supply-good status reads 0 below threshold, 1 above
// - threshold select code is passed to the battery comparator
// - reserved bits ignore writes and read zero
// - LED current register: ramp enable bit 5, current code bits 3-0
// - first interval field, 7 bits, steps of 64 ms, reset zero
// - all registers reset on power-on; factory fields load from OTP
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "pmu_regs_consts.vh"

module pmu_pin_monitor_led_regs #(
    parameter MON_250_CYCLES = `MON_250_CYC
) (
    input wire core_clk,                     // system clock, 25 MHz
    input wire nrst,                         // async reset, active low
    input wire awvalid,                      // write address valid
    output reg awready,                      // write address ready
    input wire [`ADDR_W-1:0] awaddr,         // write byte address
    input wire wvalid,                       // write data valid
    output reg wready,                       // write data ready
    input wire [31:0] wdata,                 // write data
    input wire [3:0] wstrb,                  // write byte enables
    output reg bvalid,                       // write response valid
    input wire bready,                       // write response ready
    output reg [1:0] bresp,                  // write response code
    input wire arvalid,                      // read address valid
    output reg arready,                      // read address ready
    input wire [`ADDR_W-1:0] araddr,         // read byte address
    output reg rvalid,                       // read data valid
    input wire rready,                       // read data ready
    output reg [31:0] rdata,                 // read data
    output reg [1:0] rresp,                  // read response code
    input wire [7:0] otp_pin_cfg,            // factory pin config
    input wire [7:0] otp_mon_ctrl,           // factory monitor config
    input wire sleep_state,                  // device in sleep
    input wire pin_in,                       // pad level sensed
    output reg pin_out,                      // pad drive value
    output reg pin_oe_n,                     // pad output enable, low drives
    output reg pin_pulldown_enable,          // pad pulldown on
    input wire led_third_driver_output,      // third LED driver signal
    input wire monitored_supply_input,       // comparator: 1 above threshold
    output reg supply_good_out,              // delayed supply good
    output reg monitor_switch_off_event,     // switch-off request
    output reg [1:0] monitor_threshold_select, // comparator threshold code
    output reg led_first_ramp_enable,        // LED A ramp enable
    output reg [3:0] led_first_current_code, // LED A current code
    output reg [6:0] led_first_interval_one, // LED A interval, 64 ms steps
    output reg irq                           // interrupt, active high level
);

    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_PIN = 3'h1;
    localparam [2:0] SEL_MON = 3'h2;
    localparam [2:0] SEL_LED_CUR = 3'h3;
    localparam [2:0] SEL_LED_INT = 3'h4;
    localparam [2:0] SEL_STATUS = 3'h5;
    localparam [2:0] SEL_MASK = 3'h6;
    localparam [`MON_CNT_W-1:0] LIM_50 = `MON_50_CYC;
    localparam [`MON_CNT_W-1:0] LIM_100 = `MON_100_CYC;
    localparam [`MON_CNT_W-1:0] LIM_250 = MON_250_CYCLES[`MON_CNT_W-1:0];

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function [2:0] reg_decode;
        input [`ADDR_W-1:0] addr;
        begin
            case (addr)
                {`IDX_PIN_CFG, 2'b00}: reg_decode = SEL_PIN;
                {`IDX_MON_CTRL, 2'b00}: reg_decode = SEL_MON;
                {`IDX_LED_CURRENT, 2'b00}: reg_decode = SEL_LED_CUR;
                {`IDX_LED_INTERVAL, 2'b00}: reg_decode = SEL_LED_INT;
                {`IDX_IRQ_STATUS, 2'b00}: reg_decode = SEL_STATUS;
                {`IDX_IRQ_MASK, 2'b00}: reg_decode = SEL_MASK;
                default: reg_decode = SEL_NONE;
            endcase
        end
    endfunction

    function [7:0] merge;
        input [7:0] old_val;
        input [7:0] new_val;
        input [7:0] wmask;
        begin
            merge = (old_val & ~wmask) | (new_val & wmask);
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg [7:0] pin_cfg_q;
    reg [7:0] mon_ctrl_q;
    reg [7:0] led_cur_q;
    reg [7:0] led_int_q;
    reg [`IRQ_W-1:0] irq_status_q;
    reg [`IRQ_W-1:0] irq_mask_q;
    reg load_pending_q;
    reg aw_held_q;
    reg w_held_q;
    reg [`ADDR_W-1:0] awaddr_q;
    reg [7:0] wbyte_q;
    reg wlane_q;
    reg supply_prev_q;
    reg pin_stable_prev_q;
    reg [`MON_CNT_W-1:0] fall_cnt_q;
    wire pin_stable;

    wire write_fire = aw_held_q & w_held_q & ~bvalid;
    wire [2:0] wsel = reg_decode(awaddr_q);
    wire wen = write_fire & wlane_q;
    wire [2:0] rsel = reg_decode(araddr);

    // ----------------------------------------------------------------
    // pin input debounce
    // ----------------------------------------------------------------
    // debounce window select
    pin_debounce u_debounce (
        .core_clk(core_clk),
        .nrst(nrst),
        .sample_in(pin_in),
        .long_sel(pin_cfg_q[`PIN_DEB_BIT]),
        .level_q(pin_stable)
    );

    // ----------------------------------------------------------------
    // bus write channels
    // ----------------------------------------------------------------
    // address and data are latched separately so either may come first
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= {`ADDR_W{1'b0}};
            wbyte_q <= `REG_RESET;
            wlane_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held_q <= 1'b1;
                awready <= 1'b0;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held_q <= 1'b1;
                wready <= 1'b0;
                wbyte_q <= wdata[7:0];
                wlane_q <= wstrb[0];
            end
            // write answered once both halves are in
            if (write_fire) begin
                bvalid <= 1'b1;
                bresp <= (wsel == SEL_NONE) ? `RESP_DECERR : `RESP_OKAY;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // bus read channel
    // ----------------------------------------------------------------
    reg [7:0] rbyte;
    always @* begin
        rbyte = 8'h00;
        case (rsel)
            SEL_PIN: rbyte = (pin_cfg_q & `PIN_CFG_WMASK)
                | ({7'h00, pin_in} << `PIN_STS_BIT);
            SEL_MON: rbyte = (mon_ctrl_q & `MON_CTRL_WMASK)
                | ({7'h00, monitored_supply_input} << `MON_GOOD_BIT);
            SEL_LED_CUR: rbyte = led_cur_q & `LED_CUR_WMASK;
            SEL_LED_INT: rbyte = led_int_q & `LED_INT_WMASK;
            SEL_STATUS: rbyte = {{(8-`IRQ_W){1'b0}}, irq_status_q};
            SEL_MASK: rbyte = {{(8-`IRQ_W){1'b0}}, irq_mask_q};
            default: rbyte = 8'h00;
        endcase
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                // reserved bits and upper lanes read zero
                rdata <= {24'h000000, rbyte};
                rresp <= (rsel == SEL_NONE) ? `RESP_DECERR : `RESP_OKAY;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    // factory values can't enter through async reset, so load one edge later
    wire [`IRQ_W-1:0] irq_set;
    assign irq_set[`IRQ_SUPPLY_FALL] = supply_prev_q & ~monitored_supply_input;
    assign irq_set[`IRQ_PIN_CHANGE] = pin_stable ^ pin_stable_prev_q;

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_cfg_q <= `REG_RESET;
            mon_ctrl_q <= `REG_RESET;
            led_cur_q <= `REG_RESET;
            led_int_q <= `REG_RESET;
            irq_status_q <= `IRQ_RESET;
            irq_mask_q <= `IRQ_RESET;
            load_pending_q <= 1'b1;
        end else begin
            if (load_pending_q) begin
                pin_cfg_q <= otp_pin_cfg & `PIN_CFG_WMASK;
                mon_ctrl_q <= otp_mon_ctrl & `MON_CTRL_WMASK;
                load_pending_q <= 1'b0;
            end else if (wen) begin
                case (wsel)
                    SEL_PIN: pin_cfg_q <= merge(pin_cfg_q, wbyte_q, `PIN_CFG_WMASK);
                    SEL_MON: mon_ctrl_q <= merge(mon_ctrl_q, wbyte_q, `MON_CTRL_WMASK);
                    SEL_LED_CUR: led_cur_q <= merge(led_cur_q, wbyte_q, `LED_CUR_WMASK);
                    SEL_LED_INT: led_int_q <= merge(led_int_q, wbyte_q, `LED_INT_WMASK);
                    SEL_MASK: irq_mask_q <= wbyte_q[`IRQ_W-1:0];
                    default: led_int_q <= led_int_q;
                endcase
            end
            // new events win over a same-cycle write-one clear
            if (wen && wsel == SEL_STATUS)
                irq_status_q <= (irq_status_q & ~wbyte_q[`IRQ_W-1:0]) | irq_set;
            else
                irq_status_q <= irq_status_q | irq_set;
        end
    end

    // ----------------------------------------------------------------
    // supply monitor
    // ----------------------------------------------------------------
    reg [`MON_CNT_W-1:0] fall_limit;
    always @* begin
        case (mon_ctrl_q[`MON_DELAY_HI:`MON_DELAY_LO])
            `DELAY_NONE: fall_limit = {`MON_CNT_W{1'b0}};
            `DELAY_50: fall_limit = LIM_50;
            `DELAY_100: fall_limit = LIM_100;
            default: fall_limit = LIM_250;
        endcase
    end

    // rise passes at once; the fall waits the selected delay, so for a nonzero code the interrupt is seen first
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            supply_good_out <= 1'b0;
            fall_cnt_q <= {`MON_CNT_W{1'b0}};
            supply_prev_q <= 1'b0;
            monitor_switch_off_event <= 1'b0;
            monitor_threshold_select <= 2'h0;
        end else begin
            supply_prev_q <= monitored_supply_input;
            if (monitored_supply_input) begin
                supply_good_out <= 1'b1;
                fall_cnt_q <= {`MON_CNT_W{1'b0}};
            end else if (fall_cnt_q >= fall_limit) begin
                supply_good_out <= 1'b0;
            end else begin
                fall_cnt_q <= fall_cnt_q + 1'b1;
            end
            monitor_switch_off_event <= mon_ctrl_q[`MON_MASK_BIT] & ~monitored_supply_input;
            monitor_threshold_select <= mon_ctrl_q[`MON_SEL_HI:`MON_SEL_LO];
        end
    end

    // ----------------------------------------------------------------
    // pad drive
    // ----------------------------------------------------------------
    reg pin_value_d;
    reg pin_oe_n_d;
    always @* begin
        pin_value_d = pin_cfg_q[`PIN_SRC_BIT] ? led_third_driver_output
            : pin_cfg_q[`PIN_SET_BIT];
        if (pin_cfg_q[`PIN_SLEEP_BIT] && sleep_state)
            pin_value_d = 1'b0;
        // direction, open-drain drives only the low level
        pin_oe_n_d = ~pin_cfg_q[`PIN_DIR_BIT]
            | (pin_cfg_q[`PIN_OD_BIT] & pin_value_d);
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
            pin_pulldown_enable <= 1'b0;
            pin_stable_prev_q <= 1'b0;
            led_first_ramp_enable <= 1'b0;
            led_first_current_code <= 4'h0;
            led_first_interval_one <= 7'h00;
            irq <= 1'b0;
        end else begin
            pin_out <= pin_value_d;
            pin_oe_n <= pin_oe_n_d;
            pin_pulldown_enable <= pin_cfg_q[`PIN_PD_BIT];
            pin_stable_prev_q <= pin_stable;
            led_first_ramp_enable <= led_cur_q[`LED_RAMP_BIT];
            led_first_current_code <= led_cur_q[`LED_CUR_HI:`LED_CUR_LO];
            led_first_interval_one <= led_int_q[`LED_INT_HI:`LED_INT_LO];
            irq <= |(irq_status_q & irq_mask_q);
        end
    end

endmodule

// *** test/pmu_regs_monitor.sv ***
`timescale 1ns/10ps
`include "pmu_regs_consts.vh"

module pmu_regs_monitor (
    input wire core_clk, // clock
    input wire nrst, // reset, active low
    input wire awvalid, // write address valid
    input wire awready, // write address ready
    input wire [`ADDR_W-1:0] awaddr, // write address
    input wire wvalid, // write data valid
    input wire wready, // write data ready
    input wire bvalid, // write response valid
    input wire bready, // write response ready
    input wire [1:0] bresp, // write response
    input wire arvalid, // read address valid
    input wire arready, // read address ready
    input wire [`ADDR_W-1:0] araddr, // read address
    input wire rvalid, // read data valid
    input wire rready, // read data ready
    input wire [31:0] rdata, // read data
    input wire [1:0] rresp, // read response
    input wire monitored_supply_input, // comparator result
    input wire supply_good_out, // delayed supply good
    input wire monitor_switch_off_event, // switch-off request
    input wire [6:0] led_first_interval_one // interval field
);
// ------------------------------------------------------------
// bus steps
// ------------------------------------------------------------
default clocking cb @(posedge core_clk); endclocking
default disable iff (!nrst);

// only aligned holes: unaligned decode is left to the design
function automatic logic bad_addr(input logic [`ADDR_W-1:0] a);
    return a[1:0] == 2'h0 && !(a[11:2] inside {`IDX_PIN_CFG, `IDX_MON_CTRL, `IDX_LED_CURRENT,
        `IDX_LED_INTERVAL, `IDX_IRQ_STATUS, `IDX_IRQ_MASK});
endfunction

sequence wr_take;
    awvalid && awready && wvalid && wready;
endsequence
sequence rd_take;
    arvalid && arready;
endsequence
sequence wr_bad;
    wr_take ##0 bad_addr(awaddr);
endsequence
sequence rd_bad;
    rd_take ##0 bad_addr(araddr);
endsequence

// ------------------------------------------------------------
// checks
// ------------------------------------------------------------
chk_write_answer: assert property (wr_take |=> (!awready && !wready) ##1 bvalid)
    else $error("write answer late");
chk_read_answer: assert property (rd_take |=> rvalid && !arready)
    else $error("read answer late");
chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
chk_write_hole: assert property (wr_bad |=> ##1 bvalid && bresp == `RESP_DECERR)
    else $error("unmapped write not refused");
chk_read_hole: assert property (rd_bad |=> rresp == `RESP_DECERR && rdata == 32'h0)
    else $error("unmapped read not refused");
chk_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits set");
chk_good_rise: assert property (monitored_supply_input |=> supply_good_out)
    else $error("supply good rise delayed");
chk_good_fall: assert property ($fell(supply_good_out) |-> $past(!monitored_supply_input))
    else $error("supply good fell early");
chk_switch_cause: assert property (monitor_switch_off_event |->
    $past(!monitored_supply_input)) else $error("switch-off without low supply");
chk_interval_src: assert property ($changed(led_first_interval_one) |->
    bvalid || $past(bvalid)) else $error("interval changed without a write");
endmodule

bind pmu_pin_monitor_led_regs pmu_regs_monitor u_mon (
    .core_clk, .nrst, .awvalid, .awready, .awaddr, .wvalid, .wready, .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .monitored_supply_input, .supply_good_out, .monitor_switch_off_event,
    .led_first_interval_one
);

// *** test/tb.sv ***
`timescale 1ns/10ps
`include "pmu_regs_consts.vh"

module tb;
// ------------------------------------------------------------
// stimulus and state
// ------------------------------------------------------------
localparam int MON_SIM = 20;
logic core_clk = 1'h0;
logic nrst = 1'h0;
logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
logic [`ADDR_W-1:0] awaddr = 12'h000, araddr = 12'h000;
logic [31:0] wdata = 32'h0;
logic [3:0] wstrb = 4'h0;
logic [7:0] otp_pin_cfg = 8'h00, otp_mon_ctrl = 8'h00;
logic sleep_state = 1'h0, pin_in = 1'h0, led_third_driver_output = 1'h0;
logic monitored_supply_input = 1'h1;
wire awready, wready, bvalid, arready, rvalid, pin_out, pin_oe_n, pin_pulldown_enable;
wire supply_good_out, monitor_switch_off_event, led_first_ramp_enable, irq;
wire [1:0] bresp, rresp, monitor_threshold_select;
wire [31:0] rdata;
wire [3:0] led_first_current_code;
wire [6:0] led_first_interval_one;
int checks = 0;
int n_mismatch = 0;
int cycles = 0;
logic [31:0] seed = 32'h00014D2D;
logic [9:0] ridx [4] = '{`IDX_PIN_CFG, `IDX_MON_CTRL, `IDX_LED_CURRENT, `IDX_LED_INTERVAL};
logic [7:0] rmask [4] = '{`PIN_CFG_WMASK, `MON_CTRL_WMASK, `LED_CUR_WMASK, `LED_INT_WMASK};
logic [7:0] sh [4];

pmu_pin_monitor_led_regs #(.MON_250_CYCLES(MON_SIM)) u_dut (
    .core_clk, .nrst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .otp_pin_cfg, .otp_mon_ctrl, .sleep_state, .pin_in, .pin_out, .pin_oe_n,
    .pin_pulldown_enable, .led_third_driver_output, .monitored_supply_input,
    .supply_good_out, .monitor_switch_off_event, .monitor_threshold_select,
    .led_first_ramp_enable, .led_first_current_code, .led_first_interval_one, .irq
);

always #20 core_clk = ~core_clk;

// ------------------------------------------------------------
// helpers
// ------------------------------------------------------------
function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
endfunction

// live status bits replace the shadow copy
function automatic logic [31:0] expv(input int j);
    logic [7:0] v;
    v = sh[j];
    if (j == 0) v[`PIN_STS_BIT] = pin_in;
    if (j == 1) v[`MON_GOOD_BIT] = monitored_supply_input;
    return {24'h0, v};
endfunction

function automatic logic [1:0] pad_exp();
    logic v;
    v = (sh[0][7] && sleep_state) ? 1'h0 : (sh[0][6] ? led_third_driver_output : sh[0][0]);
    return {~sh[0][2] | (sh[0][5] & v), v};
endfunction

function automatic int fall_lim(input logic [1:0] c);
    case (c)
        2'h0: return 0;
        2'h1: return `MON_50_CYC;
        2'h2: return `MON_100_CYC;
        default: return MON_SIM;
    endcase
endfunction

task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
        n_mismatch++;
        $display("mismatch %s expected %h seen %h", name, exp, got);
    end
endtask

task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [3:0] s,
                  input logic [1:0] er);
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    awaddr <= {i, 2'h0};
    wdata <= d;
    wstrb <= s;
    do begin
        @(posedge core_clk);
        if (awready) awvalid <= 1'h0;
        if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h1;
    @(posedge core_clk);
    cmp("bresp", er, bresp);
    bready <= 1'h0;
endtask

task automatic rd(input logic [9:0] i, input logic [31:0] ed, input logic [1:0] er);
    arvalid <= 1'h1;
    araddr <= {i, 2'h0};
    do begin
        @(posedge core_clk);
        if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h1;
    @(posedge core_clk);
    cmp("rdata", ed, rdata);
    cmp("rresp", er, rresp);
    rready <= 1'h0;
endtask

task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
        $display("TEST PASSED");
    end else begin
        $display("TEST FAILED");
    end
    $finish;
endtask

always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
        n_mismatch++;
        end_sim();
    end
end

// ------------------------------------------------------------
// scenarios
// ------------------------------------------------------------
initial begin
    logic [31:0] r, d;
    logic [1:0] pe;
    int j, n;
    r = rnd();
    otp_pin_cfg = r[7:0];
    otp_mon_ctrl = r[15:8];
    repeat (5) @(posedge core_clk);
    nrst <= 1'h1;
    sh[0] = otp_pin_cfg & rmask[0];
    sh[1] = otp_mon_ctrl & rmask[1];
    sh[2] = `REG_RESET;
    sh[3] = `REG_RESET;
    repeat (2) @(posedge core_clk);
    for (j = 0; j < 4; j++) begin
        rd(ridx[j], expv(j), `RESP_OKAY);
    end
    rd(`IDX_IRQ_STATUS, 32'h0, `RESP_OKAY);
    rd(`IDX_IRQ_MASK, 32'h0, `RESP_OKAY);
    for (int i = 0; i < 40; i++) begin
        r = rnd();
        j = i % 4;
        d = (i < 4) ? 32'hFFFFFFFF : rnd();
        pin_in <= r[0];
        sleep_state <= r[1];
        led_third_driver_output <= r[2];
        wr(ridx[j], d, (i < 4) ? 4'hF : r[7:4], `RESP_OKAY);
        if (i < 4 || r[4]) sh[j] = d[7:0] & rmask[j];
        rd(ridx[j], expv(j), `RESP_OKAY);
        cmp("led_current", {sh[2][5], sh[2][3:0]},
            {led_first_ramp_enable, led_first_current_code});
        cmp("led_interval", sh[3][6:0], led_first_interval_one);
        cmp("threshold", sh[1][1:0], monitor_threshold_select);
        cmp("pulldown", sh[0][3], pin_pulldown_enable);
        pe = pad_exp();
        cmp("pin_oe_n", pe[1], pin_oe_n);
        if (!pe[1]) cmp("pin_out", pe[0], pin_out);
    end
    wr(10'h3FF, 32'hFFFFFFFF, 4'hF, `RESP_DECERR);
    rd(10'h3FF, 32'h0, `RESP_DECERR);
    for (int k = 0; k < 2; k++) begin
        sh[0] = (k != 0) ? 8'h10 : 8'h00;
        wr(`IDX_PIN_CFG, {24'h0, sh[0]}, 4'h1, `RESP_OKAY);
        wr(`IDX_IRQ_MASK, (k != 0) ? 32'h0 : 32'h3, 4'h1, `RESP_OKAY);
        pin_in <= 1'h0;
        repeat (4000) @(posedge core_clk);
        wr(`IDX_IRQ_STATUS, 32'h3, 4'h1, `RESP_OKAY);
        pin_in <= 1'h1;
        n = (k != 0) ? `DEB_LONG_CYC : `DEB_SHORT_CYC;
        repeat (n - 40) @(posedge core_clk);
        rd(`IDX_IRQ_STATUS, 32'h0, `RESP_OKAY);
        repeat (60) @(posedge core_clk);
        rd(`IDX_IRQ_STATUS, 32'h2, `RESP_OKAY);
        cmp("irq", k == 0, irq);
        wr(`IDX_IRQ_STATUS, 32'h2, 4'h1, `RESP_OKAY);
        repeat (2) @(posedge core_clk);
        cmp("irq", 1'h0, irq);
        rd(`IDX_IRQ_STATUS, 32'h0, `RESP_OKAY);
    end
    for (int c = 0; c < 4; c++) begin
        d = {25'h0, c[1:0], c[0], 1'h0, 1'h0, c[1:0]};
        sh[1] = d[7:0];
        wr(`IDX_MON_CTRL, d, 4'h1, `RESP_OKAY);
        wr(`IDX_IRQ_STATUS, 32'h3, 4'h1, `RESP_OKAY);
        monitored_supply_input <= 1'h0;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (supply_good_out === 1'h1 && n < 3000);
        cmp("fall_delay", fall_lim(c[1:0]) + 2, n);
        cmp("switch_off", c[0], monitor_switch_off_event);
        cmp("threshold", c[1:0], monitor_threshold_select);
        rd(`IDX_MON_CTRL, expv(1), `RESP_OKAY);
        rd(`IDX_IRQ_STATUS, 32'h1, `RESP_OKAY);
        monitored_supply_input <= 1'h1;
        repeat (3) @(posedge core_clk);
        cmp("supply_good", 1'h1, supply_good_out);
    end
    end_sim();
end
endmodule
